// ==== hdl/nvm_ctrl_defs.vh ====
/*
  Constants for the data non-volatile memory access controller: register
  selects, control field positions, reset values and cycle timing.
  Assumes a 20 MHz system clock and inclusion by bare name.
*/
`ifndef NVM_CTRL_DEFS_VH
`define NVM_CTRL_DEFS_VH
// Register selects on the special function register port.
`define SEL_ADDRESS 2'h0
`define SEL_DATA 2'h1
`define SEL_CONTROL 2'h2
// Offset of the control register within bank 1.
`define CONTROL_OFFSET 8'h40
// Bank select value that opens bank 1.
`define BANK_ONE 8'h01
// Control field positions.
`define BIT_RD_START 0
`define BIT_RD_EN 1
`define BIT_WR_START 2
`define BIT_WR_EN 3
`define BIT_RESERVED 7
// Reset values.
`define RST_BYTE 8'h00
`define RST_ADDR 5'h00
// Number of implemented address bits and array depth.
`define ADDR_BITS 5
`define ARRAY_DEPTH 32
// Write cycle length in microseconds and the clock rate in MHz.
`define WRITE_TIME_US 2000
`define CLK_MHZ 20
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
// Slow timer tick divider: system clocks per tick of the write timer.
`define TICK_DIV 16'd625
// Read cycle length in system clocks.
`define READ_CYCLES 4'h2
`endif

// ==== hdl/nvm_write_timer.v ====
/*
  Write cycle timer for the non-volatile memory controller.
  Counts slow tick enables, standing in for the free-running low-speed
  timer; assumes the owner holds i_start high for one cycle only.
*/
`default_nettype none
module nvm_write_timer #(
  parameter integer TICK_DIV = 625,
  parameter integer TICKS = 64
) (
  input wire i_mclk,
  input wire i_arst_n,
  input wire i_start,
  output reg o_done
);
  // System clock divider producing the slow tick enable.
  reg [15:0] div_cnt;
  // Remaining ticks of the cycle in progress.
  reg [15:0] tick_cnt;
  // High while a cycle is being timed.
  reg busy;
  wire tick = (div_cnt == 16'h0000);

  // Free running divider, independent of the write requests.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt <= 16'h0000;
    end else if (tick) begin
      div_cnt <= TICK_DIV[15:0] - 16'h0001;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  // Tick counter; done pulses one cycle when the count runs out.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
      tick_cnt <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy <= 1'b1;
        tick_cnt <= TICKS[15:0];
      end else if (busy && tick) begin
        if (tick_cnt <= 16'h0001) begin
          // Final tick closes the cycle.
          busy <= 1'b0;
          tick_cnt <= 16'h0000;
          o_done <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt - 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/nvm_access_ctrl.v ====
/*
  Data non-volatile memory access controller: address, data and control
  registers, a 32 byte array, read and write sequencing and the write
  completion request. Assumes a CPU register port with a select and a write
  strobe, with the register read mux kept here, and that the CPU handles interrupt vectoring.
*/
`default_nettype none
`include "nvm_ctrl_defs.vh"
module nvm_access_ctrl #(
  parameter integer WRITE_TICKS = `WRITE_CYCLES / `TICK_DIV,
  parameter integer TICK_DIV = `TICK_DIV
) (
  input wire i_mclk,
  input wire i_arst_n,
  // Register select, write strobe and write data from the CPU.
  input wire [1:0] i_sel,
  input wire i_wr,
  input wire [7:0] i_wdata,
  // Current memory_pointer_one and bank_select, qualifying control access.
  input wire [7:0] i_memory_pointer_one,
  input wire [7:0] i_bank_select,
  // Interrupt context from the CPU.
  input wire i_nvm_done_irq_enable,
  input wire i_global_irq_enable,
  input wire i_stack_full,
  input wire i_irq_service,
  input wire i_flag_wr,
  input wire i_flag_wdata,
  // Register read back.
  output reg [7:0] o_rdata,
  output wire o_nvm_done_irq_flag,
  output wire o_irq_request,
  output wire o_clear_global_irq_enable
);
  // Registers visible to the CPU.
  reg [`ADDR_BITS-1:0] nvm_address_reg;
  reg [7:0] nvm_data_reg;
  reg reserved_top_bit;
  reg write_enable_bit;
  reg read_enable_bit;
  reg wr_start;
  reg rd_start;
  reg nvm_done_irq_flag;
  // Read cycle countdown.
  reg [3:0] rd_cnt;
  reg rd_busy;
  // Write cycle latch of address and data.
  reg [`ADDR_BITS-1:0] wr_addr;
  reg [7:0] wr_data;
  // Start pulse to the timer and its completion pulse.
  reg wr_launch;
  wire wr_done;
  // The byte array itself.
  reg [7:0] array_mem [0:`ARRAY_DEPTH-1];
  // Access qualifiers.
  wire ctrl_sel;
  wire ctrl_wr;
  wire data_wr;
  wire addr_wr;
  wire rd_finish;

  // Control is decoded only through bank one at the control offset.
  assign ctrl_sel = (i_sel == `SEL_CONTROL) && (i_memory_pointer_one == `CONTROL_OFFSET)
                    && (i_bank_select == `BANK_ONE);
  assign ctrl_wr = i_wr && ctrl_sel;
  assign data_wr = i_wr && (i_sel == `SEL_DATA);
  assign addr_wr = i_wr && (i_sel == `SEL_ADDRESS);
  assign rd_finish = rd_busy && (rd_cnt == 4'h1);

  // Write timer, running off its own slow tick.
  nvm_write_timer #(
    .TICK_DIV(TICK_DIV),
    .TICKS(WRITE_TICKS)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_start(wr_launch),
    .o_done(wr_done)
  );

  // Address register: only five bits exist.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nvm_address_reg <= `RST_ADDR;
    end else if (addr_wr) begin
      nvm_address_reg <= i_wdata[`ADDR_BITS-1:0];
    end
  end

  // Data register: CPU writes, and read results at the end of a read.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nvm_data_reg <= `RST_BYTE;
    end else if (rd_finish) begin
      nvm_data_reg <= array_mem[nvm_address_reg];
    end else if (data_wr) begin
      nvm_data_reg <= i_wdata;
    end
  end

  // Control register with self-clearing start bits.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reserved_top_bit <= 1'b0;
      write_enable_bit <= 1'b0;
      read_enable_bit <= 1'b0;
      wr_start <= 1'b0;
      rd_start <= 1'b0;
      wr_launch <= 1'b0;
      rd_busy <= 1'b0;
      rd_cnt <= 4'h0;
      wr_addr <= `RST_ADDR;
      wr_data <= `RST_BYTE;
    end else begin
      wr_launch <= 1'b0;
      if (ctrl_wr) begin
        reserved_top_bit <= i_wdata[`BIT_RESERVED];
        write_enable_bit <= i_wdata[`BIT_WR_EN];
        read_enable_bit <= i_wdata[`BIT_RD_EN];
        // Write start is taken only with the enable already set.
        if (i_wdata[`BIT_WR_START] && write_enable_bit && !wr_start && !rd_busy) begin
          wr_start <= 1'b1;
          wr_launch <= 1'b1;
          wr_addr <= nvm_address_reg;
          wr_data <= nvm_data_reg;
        end
        // Read start is taken only with the enable already set.
        if (i_wdata[`BIT_RD_START] && read_enable_bit && !rd_start && !wr_start) begin
          rd_start <= 1'b1;
          rd_busy <= 1'b1;
          rd_cnt <= `READ_CYCLES;
        end
      end
      // Read cycle countdown; start bit clears when the byte lands.
      if (rd_busy) begin
        rd_cnt <= rd_cnt - 4'h1;
        if (rd_finish) begin
          rd_busy <= 1'b0;
          rd_start <= 1'b0;
        end
      end
      // Write completion from the timer clears the start bit.
      if (wr_done) begin
        wr_start <= 1'b0;
      end
    end
  end

  // Array update only at the end of a write cycle.
  always @(posedge i_mclk) begin
    if (wr_done) begin
      array_mem[wr_addr] <= wr_data;
    end
  end

  // Completion request flag: set at write end wins over any clear.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nvm_done_irq_flag <= 1'b0;
    end else if (wr_done) begin
      nvm_done_irq_flag <= 1'b1;
    end else if (i_irq_service) begin
      nvm_done_irq_flag <= 1'b0;
    end else if (i_flag_wr) begin
      nvm_done_irq_flag <= i_flag_wdata;
    end
  end

  assign o_nvm_done_irq_flag = nvm_done_irq_flag;
  // Vector request when enabled, globally enabled and stack has room.
  assign o_irq_request = nvm_done_irq_flag && i_nvm_done_irq_enable
                         && i_global_irq_enable && !i_stack_full;
  // Servicing also drops the global enable.
  assign o_clear_global_irq_enable = i_irq_service;

  // Register read back, registered; unimplemented bits read zero.
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= `RST_BYTE;
    end else begin
      case (i_sel)
        `SEL_ADDRESS: o_rdata <= {3'h0, nvm_address_reg};
        `SEL_DATA: o_rdata <= nvm_data_reg;
        `SEL_CONTROL: begin
          if (ctrl_sel) begin
            o_rdata <= {reserved_top_bit, 3'h0, write_enable_bit, wr_start,
                        read_enable_bit, rd_start};
          end else begin
            o_rdata <= `RST_BYTE;
          end
        end
        default: o_rdata <= `RST_BYTE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/nvm_access_checker.sv ====
/*
  Port checker for the memory access controller.
  Assumes it is bound to nvm_access_ctrl and sees only its ports.
*/
`default_nettype none
module nvm_access_checker #(
  parameter integer WRITE_TICKS = 3,
  parameter integer TICK_DIV = 2
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_sel,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_memory_pointer_one,
  input wire logic [7:0] i_bank_select,
  input wire logic i_nvm_done_irq_enable,
  input wire logic i_global_irq_enable,
  input wire logic i_stack_full,
  input wire logic i_irq_service,
  input wire logic i_flag_wr,
  input wire logic i_flag_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_nvm_done_irq_flag,
  input wire logic o_irq_request,
  input wire logic o_clear_global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // The control register is open only through pointer 40h in bank one.
  wire ctl_ok = (i_memory_pointer_one == 8'h40) && (i_bank_select == 8'h01);
  // A control write that really reaches the register.
  wire ctl_wr = i_wr && (i_sel == 2'h2) && ctl_ok;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // One control write carrying a given byte.
  sequence s_cw(logic [7:0] v);
    ctl_wr && (i_wdata == v);
  endsequence
  property p_addr_top;
    i_sel == 2'h0 |=> o_rdata[7:5] == 3'h0;
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("address top bits set");
  property p_ctl_gap;
    i_sel == 2'h2 |=> o_rdata[6:4] == 3'h0;
  endproperty
  a_ctl_gap: assert property (p_ctl_gap) else $error("control gap bits set");
  property p_window;
    (i_sel == 2'h2) && !ctl_ok |=> o_rdata == 8'h00;
  endproperty
  a_window: assert property (p_window) else $error("control seen outside bank one");
  property p_reset;
    $rose(i_arst_n) |-> (o_rdata == 8'h00) && !o_nvm_done_irq_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_wr_refused;
    s_cw(8'h00) ##1 s_cw(8'h04) ##1 (!i_wr && i_sel == 2'h2) |=> o_rdata[3:0] == 4'h0;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write start taken");
  property p_rd_refused;
    s_cw(8'h00) ##1 s_cw(8'h01) ##1 (!i_wr && i_sel == 2'h2) |=> o_rdata[3:0] == 4'h0;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("read start taken");
  property p_rd_end;
    s_cw(8'h02) ##1 s_cw(8'h03) ##1 (!i_wr && i_sel == 2'h2)[*3] |=> o_rdata[1:0] == 2'b10;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read start not cleared");
  property p_irq;
    o_irq_request == (o_nvm_done_irq_flag && i_nvm_done_irq_enable
      && i_global_irq_enable && !i_stack_full);
  endproperty
  a_irq: assert property (p_irq) else $error("request level wrong");
  property p_gie_clear;
    o_clear_global_irq_enable == i_irq_service;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable clear wrong");
  property p_flag_fall;
    $fell(o_nvm_done_irq_flag) |-> $past(i_irq_service) || ($past(i_flag_wr) && !$past(i_flag_wdata));
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag dropped");
endmodule
bind nvm_access_ctrl nvm_access_checker #(.WRITE_TICKS(WRITE_TICKS), .TICK_DIV(TICK_DIV)) chk (
  .i_mclk, .i_arst_n, .i_sel, .i_wr, .i_wdata, .i_memory_pointer_one, .i_bank_select,
  .i_nvm_done_irq_enable, .i_global_irq_enable, .i_stack_full, .i_irq_service, .i_flag_wr,
  .i_flag_wdata, .o_rdata, .o_nvm_done_irq_flag, .o_irq_request, .o_clear_global_irq_enable);
`default_nettype wire

// ==== test/tb.sv ====
/*
  Bench for the memory access controller, compared with a byte model.
  Assumes short write timing set here and the checker bound beside it.
*/
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_irq_service = 1'b0, i_stack_full = 1'b0;
  logic [1:0] i_sel = 2'h0;
  logic [7:0] i_wdata = 8'h00, mp = 8'h40, bank = 8'h01, rdat;
  // Global and completion interrupt enables as the CPU would drive them.
  logic gie = 1'b1, die = 1'b1;
  wire [7:0] o_rdata;
  wire flag, irq, clr;
  int num_errors = 0, checked = 0, cyc = 0, seed = 94, n, a, i;
  int mem [32];
  int q [$];
  nvm_access_ctrl #(.WRITE_TICKS(3), .TICK_DIV(2)) DUT (.i_mclk, .i_arst_n, .i_sel, .i_wr,
    .i_wdata, .i_memory_pointer_one(mp), .i_bank_select(bank), .i_nvm_done_irq_enable(die),
    .i_global_irq_enable(gie), .i_stack_full, .i_irq_service, .i_flag_wr(1'b0),
    .i_flag_wdata(1'b0), .o_rdata, .o_nvm_done_irq_flag(flag), .o_irq_request(irq),
    .o_clear_global_irq_enable(clr));
  // Clock of 50 ns.
  initial forever #25 i_mclk = ~i_mclk;
  // Cuts a hang short well beyond the expected run length.
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  // Pseudo random numbers from a fixed start.
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One register write; the strobe stays up until the next read lowers it.
  task wr(input logic [1:0] s, input logic [7:0] v);
    @(posedge i_mclk);
    i_sel <= s;
    i_wr <= 1'b1;
    i_wdata <= v;
  endtask
  // One register read; data shows one cycle after the select.
  task rd(input logic [1:0] s);
    @(posedge i_mclk);
    i_sel <= s;
    i_wr <= 1'b0;
    @(posedge i_mclk);
    #1 rdat = o_rdata;
  endtask
  // Polls the control register until the masked start bit drops.
  task poll(input logic [7:0] m);
    i = 0;
    do begin
      rd(2'h2);
      i++;
    end while ((rdat & m) != 8'h00 && i < 40);
    `CHK("start bit", 8'h00, rdat & m)
  endtask
  task end_sim;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    // Reset held ten cycles; the write timer's tick runs steadily from release on.
    repeat (10) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    for (n = 0; n < 3; n++) begin
      rd(n[1:0]);
      `CHK("reset value", 8'h00, rdat)
    end
    $display("test reset done");
    // Starts without enables, and a control write with bank zero.
    wr(2'h2, 8'h00);
    wr(2'h2, 8'h04);
    rd(2'h2);
    `CHK("control", 8'h00, rdat)
    wr(2'h2, 8'h00);
    wr(2'h2, 8'h01);
    rd(2'h2);
    `CHK("control", 8'h00, rdat)
    @(posedge i_mclk) bank <= 8'h00;
    wr(2'h2, 8'h02);
    rd(2'h2);
    `CHK("control window", 8'h00, rdat)
    @(posedge i_mclk) bank <= 8'h01;
    rd(2'h2);
    `CHK("control", 8'h00, rdat)
    wr(2'h0, 8'hff);
    rd(2'h0);
    `CHK("address", 8'h1f, rdat)
    $display("test refusals done");
    // Writes at both ends of the array and at random places.
    for (n = 0; n < 6; n++) begin
      a = (n == 0) ? 0 : (n == 1) ? 31 : (rnd() & 31);
      mem[a] = rnd() & 255;
      q.push_back(a);
      // Stack and enable levels vary; interrupts are masked before the write.
      @(posedge i_mclk) begin
        i_stack_full <= n[0];
        die <= !n[1];
        gie <= 1'b0;
      end
      wr(2'h0, a[7:0]);
      wr(2'h1, mem[a][7:0]);
      wr(2'h2, 8'h08);
      wr(2'h2, 8'h0c);
      // The write cycle has begun: the strobe drops and interrupts return.
      @(posedge i_mclk) begin
        i_wr <= 1'b0;
        gie <= 1'b1;
      end
      poll(8'h04);
      `CHK("flag", 1'b1, flag)
      `CHK("request", !n[0] && !n[1], irq)
      @(posedge i_mclk) i_irq_service <= 1'b1;
      #1 `CHK("clear enable", 1'b1, clr)
      @(posedge i_mclk) i_irq_service <= 1'b0;
      #1 `CHK("flag", 1'b0, flag)
      wr(2'h2, 8'h00);
    end
    $display("test writes done");
    // Every read sets the address again, as software must.
    foreach (q[k]) begin
      wr(2'h0, q[k][7:0]);
      wr(2'h2, 8'h02);
      wr(2'h2, 8'h03);
      poll(8'h01);
      rd(2'h1);
      `CHK("data", mem[q[k]][7:0], rdat)
    end
    $display("test reads done");
    end_sim;
  end
endmodule
`default_nettype wire
